// ==== verilog/dcs_pkg.sv ====
// Purpose: Constants and types for the drive command source selector
// Assumes: 10 MHz mclk, 1 ms control tick, AHB-Lite register access
// Notes:   Register offsets are byte addresses of aligned 32-bit words
// Functional notes
// - Run-switch-over terminal picks main or alternative run source.
// - 2-wire: open/open stop, 1 forward, 2 reverse only when unlocked.
// - 2-wire both closed: stop, raise alarm after 500 ms.
// - Code 26 on any of terminals 3..6 selects 3-wire mode.
// - 3-wire: terminal 1 run, terminal 2 stop, terminal 5 direction.
// - 3-wire run closure must last 50 ms before starting.
// - Init value 2, 4 or 6 presets terminals 1 and 2 to fwd/rev.
// - Code 53 anywhere selects self-holding: 1 latches fwd, 2 rev.
// - Self-holding terminals 1, 2 and 5 need 50 ms closure.
// - Codes 53 and 26 together raise the terminal conflict error.
// - Run source 2 takes run commands from the serial port.
// - Run source 3 uses ladder logic engine, 4 the RTC scheduler.
// - Frequency codes: keypad, analog 1, UP/DOWN, serial, RTC, analog 2 aux.
// - Active alternative keypad source uses only speed-stage-0 value.
// - Code 13 terminal switches reference between analog inputs 1 and 2.
// - Analog 2 type 0 is voltage, 1 current (default); 1 always voltage.
// - Analog 2 function 10 adds its reference to analog 1 reference.
// - UP/DOWN source raises while UP closed, lowers while DOWN closed.
// - Run source 0 uses keypad keys; direction kept in its setting.
`default_nettype none

package dcs_pkg;

	// Timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int TICK_US         = 1000;
	localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int MIN_CLOSE_MS    = 50;
	localparam int ALARM_MS        = 500;
	localparam int MIN_CLOSE_TICKS = (MIN_CLOSE_MS * 1000 + TICK_US - 1) / TICK_US;
	localparam int ALARM_TICKS     = (ALARM_MS * 1000 + TICK_US - 1) / TICK_US;

	// Register byte offsets
	localparam logic [7:0] OFS_RUN_CFG  = 8'h00;
	localparam logic [7:0] OFS_FREQ_CFG = 8'h04;
	localparam logic [7:0] OFS_TERM_LO  = 8'h08;
	localparam logic [7:0] OFS_TERM_HI  = 8'h0C;
	localparam logic [7:0] OFS_INIT     = 8'h10;
	localparam logic [7:0] OFS_STAGE0   = 8'h14;
	localparam logic [7:0] OFS_SERIAL   = 8'h18;
	localparam logic [7:0] OFS_STATUS   = 8'h1C;
	localparam logic [7:0] OFS_FREQ_OUT = 8'h20;

	// Field positions
	localparam int RUN_MAIN_LSB = 0;
	localparam int RUN_ALT_LSB  = 4;
	localparam int DIR_LOCK_LSB = 8;
	localparam int KEY_DIR_BIT  = 12;
	localparam int FRQ_MAIN_LSB = 0;
	localparam int FRQ_ALT_LSB  = 4;
	localparam int FRQ_USE_ALT  = 8;
	localparam int AN2_TYPE_BIT = 12;
	localparam int AN2_FUNC_LSB = 16;
	localparam int SER_RUN_BIT  = 16;
	localparam int SER_REV_BIT  = 17;

	// Reset values
	localparam logic [31:0] RUN_CFG_RST  = 32'h0000_0000;
	localparam logic [31:0] FREQ_CFG_RST = 32'h000A_1000;
	localparam logic [31:0] TERM_LO_RST  = 32'hFFFF_0100;
	localparam logic [31:0] TERM_HI_RST  = 32'h0000_FFFF;

	// Terminal function codes and analog 2 function codes
	localparam logic [7:0] FC_FWD     = 8'h00;
	localparam logic [7:0] FC_REV     = 8'h01;
	localparam logic [7:0] FC_UP      = 8'h08;
	localparam logic [7:0] FC_DOWN    = 8'h09;
	localparam logic [7:0] FC_RUN_SW  = 8'h0C;
	localparam logic [7:0] FC_AI_SW   = 8'h0D;
	localparam logic [7:0] FC_3WIRE   = 8'h1A;
	localparam logic [7:0] FC_HOLD    = 8'h35;
	localparam logic [3:0] AN2_ADD    = 4'hA;
	localparam logic [3:0] AN2_AUX    = 4'h0;

	typedef enum logic [2:0] {
		RUN_KEYPAD = 3'h0, RUN_TERM = 3'h1, RUN_SERIAL = 3'h2,
		RUN_LADDER = 3'h3, RUN_RTC = 3'h4
	} dcs_run_src_type;

	typedef enum logic [2:0] {
		FRQ_KEYPAD = 3'h0, FRQ_AN1 = 3'h1, FRQ_UPDN = 3'h2,
		FRQ_SERIAL = 3'h3, FRQ_RTC = 3'h6, FRQ_AN2_AUX = 3'h7
	} dcs_frq_src_type;

	typedef enum logic [2:0] {
		MODE_TWO = 3'b001, MODE_THREE = 3'b010, MODE_HOLD = 3'b100
	} dcs_mode_type;

endpackage : dcs_pkg

`default_nettype wire

// ==== verilog/dcs_source_select.sv ====
// Purpose: Run-command and frequency-reference source selection
// Assumes: Terminals are asynchronous pins; other inputs share mclk
// Notes:   AHB-Lite slave, zero wait states, always OKAY
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`default_nettype none

module dcs_source_select
	import dcs_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int FREQ_W      = 16
) (
	// Clock and reset
	input  wire  logic              mclk,
	input  wire  logic              reset,
	// AHB-Lite slave
	input  wire  logic              hsel,
	input  wire  logic [31:0]       haddr,
	input  wire  logic [1:0]        htrans,
	input  wire  logic              hwrite,
	input  wire  logic [2:0]        hsize,
	input  wire  logic [31:0]       hwdata,
	input  wire  logic              hready,
	output logic       [31:0]       hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// Input terminals (pins), bit 0 is input_terminal_1
	input  wire  logic [5:0]        input_terminal,
	// Keypad, one-cycle key pulses
	input  wire  logic              key_run,
	input  wire  logic              key_stop,
	input  wire  logic              key_dir,
	input  wire  logic [FREQ_W-1:0] keypad_freq,
	// Other command sources
	input  wire  logic              ladder_run,
	input  wire  logic              ladder_rev,
	input  wire  logic              rtc_run,
	input  wire  logic              rtc_rev,
	input  wire  logic [FREQ_W-1:0] rtc_freq,
	input  wire  logic [FREQ_W-1:0] analog_input_1,
	input  wire  logic [FREQ_W-1:0] analog_input_2,
	// Results
	output logic                    run_cmd,
	output logic                    reverse_cmd,
	output logic       [FREQ_W-1:0] freq_ref,
	output logic                    an2_current_mode,
	output logic                    both_direction_alarm,
	output logic                    terminal_conflict_error
);

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	localparam logic [FREQ_W-1:0] FMAX = {FREQ_W{1'b1}};

	function automatic logic has_code(input logic [47:0] f,
			input logic [7:0] code, input int first);
		logic r;
		r = 1'b0;
		for (int i = first; i < 6; i++) begin
			if (f[8*i +: 8] == code) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction : has_code

	function automatic logic term_of(input logic [47:0] f,
			input logic [7:0] code, input logic [5:0] lvl);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 6; i++) begin
			if (f[8*i +: 8] == code && lvl[i]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction : term_of

	////////////////////////////////////////////////////////////////////
	// Registers and AHB-Lite slave

	logic [31:0] run_cfg_q, freq_cfg_q, term_lo_q, term_hi_q;
	logic [31:0] stage0_q, serial_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic        init_hit;
	logic [31:0] status;
	logic [47:0] func;

	wire addr_ok = hsel && hready && htrans[1];

	always_ff @(posedge mclk) begin
		if (reset) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	wire wr_en = wr_pend_q;
	assign init_hit = wr_en && wr_addr_q == OFS_INIT &&
		(hwdata[3:0] == 4'h2 || hwdata[3:0] == 4'h4 ||
		hwdata[3:0] == 4'h6);

	always_ff @(posedge mclk) begin
		if (reset) begin
			run_cfg_q  <= RUN_CFG_RST;
			freq_cfg_q <= FREQ_CFG_RST;
			term_lo_q  <= TERM_LO_RST;
			term_hi_q  <= TERM_HI_RST;
			stage0_q   <= 32'h0000_0000;
			serial_q   <= 32'h0000_0000;
		end else begin
			if (wr_en) begin
				case (wr_addr_q)
					OFS_RUN_CFG:  run_cfg_q  <= hwdata;
					OFS_FREQ_CFG: freq_cfg_q <= hwdata;
					OFS_TERM_LO:  term_lo_q  <= hwdata;
					OFS_TERM_HI:  term_hi_q  <= hwdata;
					OFS_STAGE0:   stage0_q   <= hwdata;
					OFS_SERIAL:   serial_q   <= hwdata;
					default: ;
				endcase
			end
			if (init_hit) begin
				term_lo_q[15:0] <= {FC_REV, FC_FWD};
			end
			// Keypad direction key toggles the stored direction
			if (key_dir) begin
				run_cfg_q[KEY_DIR_BIT] <= ~run_cfg_q[KEY_DIR_BIT];
			end
		end
	end

	assign func = {term_hi_q[15:0], term_lo_q};

	always_ff @(posedge mclk) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				OFS_RUN_CFG:  hrdata <= run_cfg_q;
				OFS_FREQ_CFG: hrdata <= freq_cfg_q;
				OFS_TERM_LO:  hrdata <= term_lo_q;
				OFS_TERM_HI:  hrdata <= {16'h0000, term_hi_q[15:0]};
				OFS_STAGE0:   hrdata <= stage0_q;
				OFS_SERIAL:   hrdata <= serial_q;
				OFS_STATUS:   hrdata <= status;
				OFS_FREQ_OUT: hrdata <= 32'(freq_ref);
				default:      hrdata <= 32'h0000_0000;
			endcase
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////
	// Control tick, synchroniser and minimum-closure filters

	logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_q;
	logic       tick;
	logic [5:0] term_m_q, term_s_q, term_f;

	assign tick = tick_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);

	always_ff @(posedge mclk) begin
		if (reset || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			term_m_q <= 6'h00;
			term_s_q <= 6'h00;
		end else begin
			term_m_q <= input_terminal;
			term_s_q <= term_m_q;
		end
	end

	// Filter counts ticks of continuous closure; a bounce restarts it
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_filt
			logic [7:0] cnt_q;
			always_ff @(posedge mclk) begin
				if (reset || !term_s_q[gi]) begin
					cnt_q <= 8'h00;
				end else if (tick && cnt_q != 8'(MIN_CLOSE_TICKS)) begin
					cnt_q <= cnt_q + 8'h01;
				end
			end
			assign term_f[gi] = cnt_q == 8'(MIN_CLOSE_TICKS);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Terminal mode decoding

	dcs_mode_type mode;
	logic conflict, hold_en, three_en;

	assign hold_en  = has_code(func, FC_HOLD, 0);
	assign three_en = has_code(func, FC_3WIRE, 2);
	assign conflict = hold_en && has_code(func, FC_3WIRE, 0);

	always_comb begin
		if (hold_en) begin
			mode = MODE_HOLD;
		end else if (three_en) begin
			mode = MODE_THREE;
		end else begin
			mode = MODE_TWO;
		end
	end

	logic       rev_ok, lat_run_q, lat_rev_q, f1_q, f2_q;
	logic       tw_fwd, tw_rev, tw_both;
	logic [9:0] both_cnt_q;

	assign rev_ok  = run_cfg_q[DIR_LOCK_LSB +: 2] == 2'b00;
	assign tw_fwd  = term_of(func, FC_FWD, term_s_q);
	assign tw_rev  = term_of(func, FC_REV, term_s_q);
	assign tw_both = mode == MODE_TWO && tw_fwd && tw_rev;

	// Latch for 3-wire and self-holding; starts on filtered edges, stops on filtered levels
	always_ff @(posedge mclk) begin
		if (reset) begin
			lat_run_q <= 1'b0;
			lat_rev_q <= 1'b0;
			f1_q      <= 1'b0;
			f2_q      <= 1'b0;
		end else begin
			f1_q <= term_f[0];
			f2_q <= term_f[1];
			case (mode)
				MODE_THREE: begin
					if (!term_f[1]) begin
						lat_run_q <= 1'b0;
					end else if (term_f[0] && !f1_q) begin
						lat_run_q <= 1'b1;
					end
					lat_rev_q <= term_f[4];
				end
				MODE_HOLD: begin
					if (!term_f[4]) begin
						lat_run_q <= 1'b0;
					end else if (term_f[0] && !f1_q) begin
						lat_run_q <= 1'b1;
						lat_rev_q <= 1'b0;
					end else if (term_f[1] && !f2_q) begin
						lat_run_q <= 1'b1;
						lat_rev_q <= 1'b1;
					end
				end
				default: begin
					lat_run_q <= 1'b0;
					lat_rev_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || !tw_both) begin
			both_cnt_q <= 10'h000;
		end else if (tick && both_cnt_q != 10'(ALARM_TICKS)) begin
			both_cnt_q <= both_cnt_q + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Run command source

	logic [2:0] run_src;
	logic       key_run_q, run_d, rev_d;

	assign run_src = term_of(func, FC_RUN_SW, term_s_q) ?
		run_cfg_q[RUN_ALT_LSB +: 3] : run_cfg_q[RUN_MAIN_LSB +: 3];

	always_ff @(posedge mclk) begin
		if (reset || key_stop) begin
			key_run_q <= 1'b0;
		end else if (key_run) begin
			key_run_q <= 1'b1;
		end
	end

	always_comb begin
		run_d = 1'b0;
		rev_d = 1'b0;
		case (run_src)
			RUN_KEYPAD: begin
				run_d = key_run_q;
				rev_d = run_cfg_q[KEY_DIR_BIT];
			end
			RUN_TERM: begin
				if (mode == MODE_TWO) begin
					run_d = tw_fwd ^ tw_rev;
					rev_d = tw_rev && !tw_fwd;
				end else begin
					run_d = lat_run_q && !conflict;
					rev_d = lat_rev_q;
				end
			end
			RUN_SERIAL: begin
				run_d = serial_q[SER_RUN_BIT];
				rev_d = serial_q[SER_REV_BIT];
			end
			RUN_LADDER: begin
				run_d = ladder_run;
				rev_d = ladder_rev;
			end
			RUN_RTC: begin
				run_d = rtc_run;
				rev_d = rtc_rev;
			end
			default: ;
		endcase
		// Reverse request with direction lock set becomes a stop
		if (rev_d && !rev_ok) begin
			run_d = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			run_cmd                 <= 1'b0;
			reverse_cmd             <= 1'b0;
			both_direction_alarm    <= 1'b0;
			terminal_conflict_error <= 1'b0;
		end else begin
			run_cmd                 <= run_d;
			reverse_cmd             <= rev_d && run_d;
			both_direction_alarm    <= both_cnt_q == 10'(ALARM_TICKS);
			terminal_conflict_error <= conflict;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Frequency reference source

	logic [FREQ_W-1:0] updn_q, ai_ref, freq_d;
	logic [FREQ_W:0]   ai_sum;
	logic [2:0]        frq_src;
	logic              use_alt, up_on, dn_on;

	assign use_alt = freq_cfg_q[FRQ_USE_ALT];
	assign frq_src = use_alt ? freq_cfg_q[FRQ_ALT_LSB +: 3] :
		freq_cfg_q[FRQ_MAIN_LSB +: 3];
	assign up_on = term_of(func, FC_UP, term_s_q);
	assign dn_on = term_of(func, FC_DOWN, term_s_q);
	assign an2_current_mode = freq_cfg_q[AN2_TYPE_BIT];

	// With UP and DOWN both closed, or both open, the setpoint just holds
	always_ff @(posedge mclk) begin
		if (reset) begin
			updn_q <= '0;
		end else if (tick && up_on && !dn_on && updn_q != FMAX) begin
			updn_q <= updn_q + 1'b1;
		end else if (tick && dn_on && !up_on && updn_q != '0) begin
			updn_q <= updn_q - 1'b1;
		end
	end

	assign ai_sum = {1'b0, analog_input_1} + {1'b0, analog_input_2};

	always_comb begin
		if (freq_cfg_q[AN2_FUNC_LSB +: 4] == AN2_ADD) begin
			ai_ref = ai_sum[FREQ_W] ? FMAX : ai_sum[FREQ_W-1:0];
		end else if (term_of(func, FC_AI_SW, term_s_q)) begin
			ai_ref = analog_input_2;
		end else begin
			ai_ref = analog_input_1;
		end
	end

	always_comb begin
		case (frq_src)
			FRQ_KEYPAD:
				freq_d = use_alt ? stage0_q[FREQ_W-1:0] : keypad_freq;
			FRQ_AN1:    freq_d = ai_ref;
			FRQ_UPDN:   freq_d = updn_q;
			FRQ_SERIAL: freq_d = serial_q[FREQ_W-1:0];
			FRQ_RTC:    freq_d = rtc_freq;
			FRQ_AN2_AUX:
				freq_d = freq_cfg_q[AN2_FUNC_LSB +: 4] == AN2_AUX ?
					analog_input_2 : '0;
			default:    freq_d = '0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			freq_ref <= '0;
		end else begin
			freq_ref <= freq_d;
		end
	end

	assign status = {10'h000, term_f, 1'b0, mode, 1'b0, frq_src,
		1'b0, run_src, terminal_conflict_error, both_direction_alarm,
		reverse_cmd, run_cmd};

	////////////////////////////////////////////////////////////////////
	// Assertions

	logic [31:0] closed_cyc_q;
	always_ff @(posedge mclk) begin
		if (reset || !term_s_q[0]) begin
			closed_cyc_q <= 32'h0000_0000;
		end else if (closed_cyc_q != 32'hFFFF_FFFF) begin
			closed_cyc_q <= closed_cyc_q + 32'h0000_0001;
		end
	end

	property p_both_stop;
		run_src == RUN_TERM && tw_both |=> !run_cmd;
	endproperty
	a_both_stop: assert property (p_both_stop)
		else $error("motor runs with both direction terminals closed");

	property p_alarm_late;
		$rose(both_direction_alarm) |->
			$past(both_cnt_q) == 10'(ALARM_TICKS) && $past(tw_both);
	endproperty
	a_alarm_late: assert property (p_alarm_late)
		else $error("alarm raised before full persistence time");

	property p_filter_len;
		term_f[0] |->
			closed_cyc_q >= 32'((MIN_CLOSE_TICKS - 1) * TICK_CYCLES);
	endproperty
	a_filter_len: assert property (p_filter_len)
		else $error("terminal qualified before minimum closure");

	property p_conflict;
		conflict |=> terminal_conflict_error &&
			(!run_cmd || $past(run_src) != RUN_TERM);
	endproperty
	a_conflict: assert property (p_conflict)
		else $error("conflict error missing or drive still running");

	property p_rev_lock;
		!rev_ok |=> !reverse_cmd;
	endproperty
	a_rev_lock: assert property (p_rev_lock)
		else $error("reverse run while direction lock set");

	property p_serial;
		run_src == RUN_SERIAL && !serial_q[SER_REV_BIT] |=>
			run_cmd == $past(serial_q[SER_RUN_BIT]);
	endproperty
	a_serial: assert property (p_serial)
		else $error("serial run command not followed");

	property p_stage0;
		use_alt && freq_cfg_q[FRQ_ALT_LSB +: 3] == 3'h0 |=>
			freq_ref == $past(stage0_q[FREQ_W-1:0]);
	endproperty
	a_stage0: assert property (p_stage0)
		else $error("alternative keypad source not from stage zero");

	property p_init;
		init_hit |=> term_lo_q[15:0] == {FC_REV, FC_FWD};
	endproperty
	a_init: assert property (p_init)
		else $error("initialization preset not applied to terminals");

	property p_updn;
		tick && up_on && !dn_on && updn_q != FMAX |=>
			updn_q == $past(updn_q) + 1'b1;
	endproperty
	a_updn: assert property (p_updn)
		else $error("UP terminal did not raise the setpoint");

	property p_three_stop;
		mode == MODE_THREE && !term_f[1] |=> ##1 !lat_run_q;
	endproperty
	a_three_stop: assert property (p_three_stop)
		else $error("3-wire stop terminal open but run latched");

endmodule : dcs_source_select

`default_nettype wire

// ==== verif/dcs_switch_model.sv ====
// Purpose: Far-side model: operator switch contacts and command sources
// Assumes: Contacts move only right after a rising mclk edge
// Notes:   Closure length is the caller's choice; no contact bounce
`default_nettype none

module dcs_switch_model #(
	parameter logic [15:0] AI1_VAL = 16'h1234,
	parameter logic [15:0] AI2_VAL = 16'h0456,
	parameter logic [15:0] RTC_VAL = 16'h0789
) (
	// Clock
	input  wire logic        mclk,
	// Switch contacts, high is closed
	output var  logic [5:0]  input_terminal,
	// Frequency sources
	output var  logic [15:0] analog_input_1,
	output var  logic [15:0] analog_input_2,
	output var  logic [15:0] rtc_freq,
	// Engine run requests
	output var  logic        ladder_run,
	output var  logic        ladder_rev,
	output var  logic        rtc_run,
	output var  logic        rtc_rev
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		input_terminal = 6'h00;
		analog_input_1 = AI1_VAL;
		analog_input_2 = AI2_VAL;
		rtc_freq = RTC_VAL;
		{ladder_run, ladder_rev, rtc_run, rtc_rev} = 4'h0;
	end

	////////////////////////////////////////////////////////////////////
	// Contacts stay put for the whole span; short spans probe the filter
	task automatic set_sw(input logic [5:0] v, input int cycles);
		@(posedge mclk);
		input_terminal <= v;
		repeat (cycles) @(posedge mclk);
	endtask : set_sw

	task automatic set_eng(input logic [3:0] v);
		@(posedge mclk);
		{ladder_run, ladder_rev, rtc_run, rtc_rev} <= v;
	endtask : set_eng

endmodule : dcs_switch_model

`default_nettype wire

// ==== verif/tb_drive_command_source_select.sv ====
// Purpose: Self-checking bench for the command source selector
// Assumes: Tick shortened to 10 cycles, so 50 ms is 500 cycles
// Notes:   Registers reached through an AHB-Lite single-word master
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
	end end

module tb_drive_command_source_select
	import dcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int          TICK = 10;
	localparam int          HOLD = 60 * TICK;
	localparam int          SHORT = 30 * TICK;
	localparam logic [15:0] A1 = 16'h1234;
	localparam logic [15:0] A2 = 16'h0456;
	localparam logic [15:0] RT = 16'h0789;

	logic        mclk, reset, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize, keys;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [5:0]  input_terminal;
	logic [15:0] keypad_freq, rtc_freq, analog_input_1, analog_input_2;
	logic [15:0] freq_ref, f0, f1;
	logic        ladder_run, ladder_rev, rtc_run, rtc_rev;
	logic        run_cmd, reverse_cmd, an2_current_mode;
	logic        both_direction_alarm, terminal_conflict_error;
	int          num_errors, checks_done;
	logic [15:0] fexp [6];
	logic [2:0]  fcode [6];

	assign hready = hreadyout;

	dcs_source_select #(.TICK_CYCLES(TICK), .FREQ_W(16)) DUT (
		.mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .input_terminal,
		.key_run(keys[0]), .key_stop(keys[1]), .key_dir(keys[2]),
		.keypad_freq, .ladder_run, .ladder_rev, .rtc_run, .rtc_rev,
		.rtc_freq, .analog_input_1, .analog_input_2, .run_cmd,
		.reverse_cmd, .freq_ref, .an2_current_mode, .both_direction_alarm,
		.terminal_conflict_error
	);

	dcs_switch_model #(.AI1_VAL(A1), .AI2_VAL(A2), .RTC_VAL(RT)) sw (
		.mclk, .input_terminal, .analog_input_1, .analog_input_2,
		.rtc_freq, .ladder_run, .ladder_rev, .rtc_run, .rtc_rev
	);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (num_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	// Address phase held until hready, then data phase until hready
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rchk(string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		`CHK(nm, e, rd)
	endtask : rchk

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask : wt

	task automatic pulse(input logic [2:0] k);
		@(posedge mclk);
		keys <= k;
		@(posedge mclk);
		keys <= 3'h0;
		wt(3);
	endtask : pulse

	initial begin
		#5000000;
		num_errors++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		{reset, hsel, hwrite, htrans, keys} = 8'h80;
		hsize = 3'h2;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		keypad_freq = 16'h0321;
		num_errors = 0;
		checks_done = 0;
		fcode = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h6, 3'h7};
		fexp = '{16'h0321, A1, 16'h0ABC, 16'h0000, RT, A2};
		wt(5);
		reset <= 1'b0;
		rchk("run_cfg", OFS_RUN_CFG, RUN_CFG_RST);
		rchk("freq_cfg", OFS_FREQ_CFG, FREQ_CFG_RST);
		rchk("term_lo", OFS_TERM_LO, TERM_LO_RST);
		rchk("term_hi", OFS_TERM_HI, TERM_HI_RST);
		rchk("unmapped", 8'h40, 32'h00000000);
		`CHK("hresp", 1'b0, hresp)
		`CHK("hreadyout", 1'b1, hreadyout)
		`CHK("an2_type", 1'b1, an2_current_mode)
		// Two-wire on the reset terminal codes 0 and 1
		wr(OFS_RUN_CFG, 32'h00000001);
		sw.set_sw(6'h01, 6);
		`CHK("fwd_run", 2'b10, {run_cmd, reverse_cmd})
		sw.set_sw(6'h02, 6);
		`CHK("rev_run", 2'b11, {run_cmd, reverse_cmd})
		wr(OFS_RUN_CFG, 32'h00000101);
		wt(3);
		`CHK("rev_locked", 1'b0, run_cmd)
		wr(OFS_RUN_CFG, 32'h00000001);
		sw.set_sw(6'h03, 4900);
		`CHK("both_stop", 2'b00, {run_cmd, both_direction_alarm})
		wt(200);
		`CHK("alarm", 1'b1, both_direction_alarm)
		sw.set_sw(6'h00, 6);
		`CHK("alarm_clr", 1'b0, both_direction_alarm)
		wr(OFS_TERM_HI, 32'h0000351A);
		wt(3);
		`CHK("conflict", 1'b1, terminal_conflict_error)
		wr(OFS_TERM_HI, 32'h0000FFFF);
		wt(3);
		`CHK("no_conflict", 1'b0, terminal_conflict_error)
		// Terminal 3 swaps terminals for the serial source
		wr(OFS_TERM_LO, 32'hFF0C0100);
		wr(OFS_RUN_CFG, 32'h00000021);
		wr(OFS_SERIAL, 32'h00010000);
		sw.set_sw(6'h04, 6);
		`CHK("alt_serial", 1'b1, run_cmd)
		sw.set_sw(6'h00, 6);
		`CHK("main_term", 1'b0, run_cmd)
		sw.set_eng(4'hC);
		wr(OFS_RUN_CFG, 32'h00000003);
		wt(3);
		`CHK("ladder", 2'b11, {run_cmd, reverse_cmd})
		sw.set_eng(4'h2);
		wr(OFS_RUN_CFG, 32'h00000004);
		wt(3);
		`CHK("rtc", 2'b10, {run_cmd, reverse_cmd})
		wr(OFS_RUN_CFG, 32'h00000000);
		pulse(3'h1);
		`CHK("key_run", 1'b1, run_cmd)
		pulse(3'h4);
		`CHK("key_dir", 1'b1, reverse_cmd)
		rchk("dir_kept", OFS_RUN_CFG, 32'h00001000);
		pulse(3'h2);
		`CHK("key_stop", 1'b0, run_cmd)
		// Three-wire: terminal 2 must be closed to release stop
		wr(OFS_RUN_CFG, 32'h00000001);
		wr(OFS_TERM_LO, 32'hFFFF0100);
		wr(OFS_TERM_HI, 32'h00001AFF);
		bus(1'b0, OFS_STATUS, 32'h00000000);
		`CHK("mode3", 3'b010, rd[14:12])
		sw.set_sw(6'h02, HOLD);
		sw.set_sw(6'h03, SHORT);
		sw.set_sw(6'h02, 6);
		`CHK("short_run", 1'b0, run_cmd)
		sw.set_sw(6'h03, HOLD);
		`CHK("run3", 2'b10, {run_cmd, reverse_cmd})
		sw.set_sw(6'h13, HOLD);
		`CHK("rev3", 1'b1, reverse_cmd)
		sw.set_sw(6'h11, 6);
		`CHK("stop3", 1'b0, run_cmd)
		// Self-holding with terminal 5 as the enable
		wr(OFS_TERM_HI, 32'h000035FF);
		bus(1'b0, OFS_STATUS, 32'h00000000);
		`CHK("mode_hold", 3'b100, rd[14:12])
		sw.set_sw(6'h10, HOLD);
		sw.set_sw(6'h11, HOLD);
		sw.set_sw(6'h10, 6);
		`CHK("latch_fwd", 2'b10, {run_cmd, reverse_cmd})
		sw.set_sw(6'h12, HOLD);
		`CHK("latch_rev", 2'b11, {run_cmd, reverse_cmd})
		sw.set_sw(6'h00, 6);
		sw.set_sw(6'h10, HOLD);
		sw.set_sw(6'h11, SHORT);
		sw.set_sw(6'h10, 6);
		`CHK("short_hold", 1'b0, run_cmd)
		wr(OFS_TERM_HI, 32'h0000FFFF);
		sw.set_sw(6'h00, 6);
		for (int i = 2; i <= 6; i++) begin
			wr(OFS_TERM_LO, 32'hFFFFFFFF);
			wr(OFS_INIT, i);
			rchk("init", OFS_TERM_LO, i % 2 ? 32'hFFFFFFFF : 32'hFFFF0100);
		end
		// Frequency sources; terminal 5 switches the analog input
		wr(OFS_TERM_LO, 32'h09080100);
		wr(OFS_TERM_HI, 32'h0000FF0D);
		wr(OFS_SERIAL, 32'h00000ABC);
		wr(OFS_STAGE0, 32'h00000222);
		for (int i = 0; i < 6; i++) begin
			wr(OFS_FREQ_CFG, {29'h00000200, fcode[i]});
			wt(3);
			`CHK("freq_src", fexp[i], freq_ref)
		end
		wr(OFS_FREQ_CFG, 32'h00001101);
		wt(3);
		`CHK("alt_keypad", 16'h0222, freq_ref)
		wr(OFS_FREQ_CFG, 32'h00001001);
		sw.set_sw(6'h10, HOLD);
		`CHK("ai_sw", A2, freq_ref)
		sw.set_sw(6'h00, HOLD);
		`CHK("ai_sw_back", A1, freq_ref)
		wr(OFS_FREQ_CFG, 32'h000A1001);
		wt(3);
		`CHK("ai_sum", A1 + A2, freq_ref)
		wr(OFS_FREQ_CFG, 32'h000A1007);
		wt(3);
		`CHK("aux_off", 16'h0000, freq_ref)
		wr(OFS_FREQ_CFG, 32'h00000000);
		wt(3);
		`CHK("an2_volt", 1'b0, an2_current_mode)
		wr(OFS_FREQ_CFG, 32'h00001002);
		wt(3);
		f0 = freq_ref;
		sw.set_sw(6'h04, HOLD);
		f1 = freq_ref;
		`CHK("up", 1'b1, f1 > f0)
		sw.set_sw(6'h08, HOLD);
		`CHK("down", 1'b1, freq_ref < f1)
		finish_test();
	end

endmodule : tb_drive_command_source_select

`default_nettype wire
